/* File: hw/mlfc_params.svh */
`ifndef MLFC_PARAMS_SVH
`define MLFC_PARAMS_SVH
// register offsets
`define MLFC_OFS_FAULT2    8'h92
`define MLFC_OFS_STATUS    8'ha0
`define MLFC_OFS_MASK      8'ha1
// field positions in the fault setting word
`define MLFC_BIT_RSVD      31
`define MLFC_BIT_SPD_EN    30
`define MLFC_BIT_BACK_EMF_EN   29
`define MLFC_BIT_ABS_EN    28
`define MLFC_SPD_THR_HI    27
`define MLFC_SPD_THR_LO    25
`define MLFC_BACK_EMF_THR_HI   24
`define MLFC_BACK_EMF_THR_LO   22
// event bit positions in status and mask
`define MLFC_EVT_SPD       0
`define MLFC_EVT_BACK_EMF      1
`define MLFC_EVT_ABS       2
`define MLFC_EVT_CFG       3
`define MLFC_NUM_EVT       4
// reset values
`define MLFC_RST_EN        1'b0
`define MLFC_RST_THR       3'h0
`define MLFC_RST_EVT       4'h0
`define MLFC_RST_PCT       11'h000
// threshold decode, tenths of a percent
`define MLFC_SPD_BASE_X10  11'h514
`define MLFC_SPD_STEP_X10  11'h064
`define MLFC_BACK_EMF_X10_0    11'h190
`define MLFC_BACK_EMF_X10_1    11'h1c2
`define MLFC_BACK_EMF_X10_2    11'h1f4
`define MLFC_BACK_EMF_X10_3    11'h226
`define MLFC_BACK_EMF_X10_4    11'h258
`define MLFC_BACK_EMF_X10_5    11'h28a
`define MLFC_BACK_EMF_X10_6    11'h2a3
`define MLFC_BACK_EMF_X10_7    11'h2bc
`endif

/* File: hw/mlfc_pkg.sv */
package mlfc_pkg;
    // three-bit threshold code as stored
    typedef logic [2:0] mlfc_code_t;
    // decoded threshold in tenths of a percent
    typedef logic [10:0] mlfc_pct_t;
    // register selected by the current address
    typedef enum logic [1:0] {
        MLFC_SEL_NONE,
        MLFC_SEL_FAULT2,
        MLFC_SEL_STATUS,
        MLFC_SEL_MASK
    } mlfc_sel_t;
endpackage

/* File: hw/mlfc_cfg_if.sv */
`timescale 1ns/1ps
// threshold codes out, decoded percentages back
interface mlfc_cfg_if;
    mlfc_pkg::mlfc_code_t speed_code;
    mlfc_pkg::mlfc_code_t back_emf_code;
    mlfc_pkg::mlfc_pct_t  speed_pct;
    mlfc_pkg::mlfc_pct_t  back_emf_pct;
    modport ctl (output speed_code, output back_emf_code, input speed_pct, input back_emf_pct);
    modport dec (input speed_code, input back_emf_code, output speed_pct, output back_emf_pct);
endinterface

/* File: hw/mlfc_thr_dec.sv */
`timescale 1ns/1ps
`include "mlfc_params.svh"
module mlfc_thr_dec (
    mlfc_cfg_if.dec cfg
);
    // speed threshold is linear: base plus code times step
    always_comb begin
        cfg.speed_pct = `MLFC_SPD_BASE_X10 + (`MLFC_SPD_STEP_X10 * {8'h00, cfg.speed_code});
    end

    // back emf steps are irregular near the top, so a table
    always_comb begin
        case (cfg.back_emf_code)
            3'h0: cfg.back_emf_pct = `MLFC_BACK_EMF_X10_0;
            3'h1: cfg.back_emf_pct = `MLFC_BACK_EMF_X10_1;
            3'h2: cfg.back_emf_pct = `MLFC_BACK_EMF_X10_2;
            3'h3: cfg.back_emf_pct = `MLFC_BACK_EMF_X10_3;
            3'h4: cfg.back_emf_pct = `MLFC_BACK_EMF_X10_4;
            3'h5: cfg.back_emf_pct = `MLFC_BACK_EMF_X10_5;
            3'h6: cfg.back_emf_pct = `MLFC_BACK_EMF_X10_6;
            3'h7: cfg.back_emf_pct = `MLFC_BACK_EMF_X10_7;
            default: cfg.back_emf_pct = `MLFC_BACK_EMF_X10_0;
        endcase
    end
endmodule // mlfc_thr_dec

/* File: hw/mlfc_sticky.sv */
`timescale 1ns/1ps
`include "mlfc_params.svh"
module mlfc_sticky #(
    parameter int N = 4
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [N-1:0] set_i,
    input  wire logic [N-1:0] clr_i,
    input  wire logic [N-1:0] mask_i,
    output logic      [N-1:0] status_o,
    output logic              irq_o
);
    if (N < 1) begin : g_chk
        $error("mlfc_sticky needs at least one event");
    end

    // one flag per event; set beats a clear in the same cycle
    for (genvar i = 0; i < N; i++) begin : g_flag
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                status_o[i] <= 1'b0;
            end else if (set_i[i]) begin
                status_o[i] <= 1'b1;
            end else if (clr_i[i]) begin
                status_o[i] <= 1'b0;
            end
        end
    end

    // level interrupt while any unmasked flag stands
    assign irq_o = |(status_o & mask_i);
endmodule // mlfc_sticky

/* File: hw/mlfc_top.sv */
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "mlfc_params.svh"
// How it works
// - the fault setting word sits at offset 92h and every field clears to zero on reset.
// - bit 31 is reserved, read only, and always reads zero.
// - bit 30 enables the overspeed lock detector, read/write, disabled after reset.
// - bit 29 enables the back emf lock detector, read/write, disabled after reset.
// - bit 28 enables the absent motor lock detector, read/write, disabled after reset.
// - bits 27:25 pick the overspeed threshold, 130% plus 10% per code up to 200%.
// - bits 24:22 pick the back emf threshold from 40,45,50,55,60,65,67.5 and 70 percent.
module mlfc_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  wire logic              speed_lock_detect,
    input  wire logic              backemf_lock_detect,
    input  wire logic              absent_motor_detect,
    output logic                   speed_lock_enable,
    output logic                   backemf_lock_enable,
    output logic                   absent_motor_lock_enable,
    output logic      [2:0]        overspeed_lock_threshold,
    output logic      [2:0]        backemf_lock_threshold,
    output logic      [10:0]       overspeed_limit_x10,
    output logic      [10:0]       backemf_limit_x10,
    output logic                   cfg_update,
    output logic      [2:0]        lock_fault,
    output logic                   any_lock_fault,
    output logic                   irq
);
    // the offsets are eight bits wide; a narrower bus cannot reach them
    if (ADDR_W < 8) begin : g_chk
        $error("mlfc_top needs ADDR_W of at least 8");
    end

    // the readback packs the fields by position; an overlap would alias bits
    if (`MLFC_SPD_THR_LO <= `MLFC_BACK_EMF_THR_HI) begin : g_chk_fields
        $error("mlfc_top threshold fields overlap");
    end

    // every event needs its own flag inside the low status bits
    if (`MLFC_EVT_CFG >= `MLFC_NUM_EVT || `MLFC_NUM_EVT > 28) begin : g_chk_evt
        $error("mlfc_top event vector does not fit");
    end

    // the three offsets must decode apart, or one register would shadow another
    if (`MLFC_OFS_FAULT2 == `MLFC_OFS_STATUS || `MLFC_OFS_FAULT2 == `MLFC_OFS_MASK
        || `MLFC_OFS_STATUS == `MLFC_OFS_MASK) begin : g_chk_ofs
        $error("mlfc_top register offsets collide");
    end

    // stored configuration
    logic                 spd_en_q;
    logic                 back_emf_en_q;
    logic                 abs_en_q;
    mlfc_pkg::mlfc_code_t spd_thr_q;
    mlfc_pkg::mlfc_code_t back_emf_thr_q;
    logic [`MLFC_NUM_EVT-1:0] mask_q;

    // map on reg_addr: setting word, then status (write one to clear) and mask
    // status and mask bits: overspeed, back emf, absent motor, setting written
    // a read answers in the next cycle only; unmapped places read zero
    // bus side
    mlfc_pkg::mlfc_sel_t  sel;
    logic                 wr_fault2;
    logic                 wr_status;
    logic                 wr_mask;
    logic [31:0]          fault2_word;
    logic [31:0]          rdata_d;
    logic [31:0]          rdata_q;

    // detector side
    logic [2:0]           det_raw;
    logic [2:0]           det_en;
    logic [2:0]           det_act;
    logic [2:0]           det_prev_q;
    logic [2:0]           det_rise;
    logic [2:0]           lock_fault_q;
    logic                 any_fault_q;
    logic                 cfg_update_q;
    mlfc_pkg::mlfc_pct_t  spd_pct_q;
    mlfc_pkg::mlfc_pct_t  back_emf_pct_q;

    // interrupt side
    logic [`MLFC_NUM_EVT-1:0] evt_set;
    logic [`MLFC_NUM_EVT-1:0] evt_clr;
    logic [`MLFC_NUM_EVT-1:0] evt_status;
    logic                     irq_raw;

    mlfc_cfg_if cfg_bus ();

    // address decode; anything unlisted selects nothing
    always_comb begin
        if (reg_addr == ADDR_W'(`MLFC_OFS_FAULT2)) begin
            sel = mlfc_pkg::MLFC_SEL_FAULT2;
        end else if (reg_addr == ADDR_W'(`MLFC_OFS_STATUS)) begin
            sel = mlfc_pkg::MLFC_SEL_STATUS;
        end else if (reg_addr == ADDR_W'(`MLFC_OFS_MASK)) begin
            sel = mlfc_pkg::MLFC_SEL_MASK;
        end else begin
            sel = mlfc_pkg::MLFC_SEL_NONE;
        end
    end

    // write strobes per register
    assign wr_fault2 = reg_wr && (sel == mlfc_pkg::MLFC_SEL_FAULT2);
    assign wr_status = reg_wr && (sel == mlfc_pkg::MLFC_SEL_STATUS);
    assign wr_mask   = reg_wr && (sel == mlfc_pkg::MLFC_SEL_MASK);

    // overspeed detector enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spd_en_q <= `MLFC_RST_EN;
        end else if (wr_fault2) begin
            spd_en_q <= reg_wdata[`MLFC_BIT_SPD_EN];
        end
    end

    // back emf detector enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            back_emf_en_q <= `MLFC_RST_EN;
        end else if (wr_fault2) begin
            back_emf_en_q <= reg_wdata[`MLFC_BIT_BACK_EMF_EN];
        end
    end

    // absent motor detector enable
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            abs_en_q <= `MLFC_RST_EN;
        end else if (wr_fault2) begin
            abs_en_q <= reg_wdata[`MLFC_BIT_ABS_EN];
        end
    end

    // overspeed threshold code; bit 31 and the low fields have no storage at all
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spd_thr_q <= `MLFC_RST_THR;
        end else if (wr_fault2) begin
            spd_thr_q <= reg_wdata[`MLFC_SPD_THR_HI:`MLFC_SPD_THR_LO];
        end
    end

    // back emf threshold code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            back_emf_thr_q <= `MLFC_RST_THR;
        end else if (wr_fault2) begin
            back_emf_thr_q <= reg_wdata[`MLFC_BACK_EMF_THR_HI:`MLFC_BACK_EMF_THR_LO];
        end
    end

    // interrupt mask, one bit per event
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_q <= `MLFC_RST_EVT;
        end else if (wr_mask) begin
            mask_q <= reg_wdata[`MLFC_NUM_EVT-1:0];
        end
    end

    // readback image of the fault setting word
    always_comb begin
        fault2_word = 32'h0000_0000;
        fault2_word[`MLFC_BIT_RSVD] = 1'b0;
        fault2_word[`MLFC_BIT_SPD_EN] = spd_en_q;
        fault2_word[`MLFC_BIT_BACK_EMF_EN] = back_emf_en_q;
        fault2_word[`MLFC_BIT_ABS_EN] = abs_en_q;
        fault2_word[`MLFC_SPD_THR_HI:`MLFC_SPD_THR_LO] = spd_thr_q;
        fault2_word[`MLFC_BACK_EMF_THR_HI:`MLFC_BACK_EMF_THR_LO] = back_emf_thr_q;
    end

    // read mux; unmapped addresses answer zero
    always_comb begin
        case (sel)
            mlfc_pkg::MLFC_SEL_FAULT2: begin
                rdata_d = fault2_word;
            end
            mlfc_pkg::MLFC_SEL_STATUS: begin
                rdata_d = {28'h000_0000, evt_status};
            end
            mlfc_pkg::MLFC_SEL_MASK: begin
                rdata_d = {28'h000_0000, mask_q};
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_q;

    // enables go straight out so the detectors track the stored bits
    assign speed_lock_enable        = spd_en_q;
    assign backemf_lock_enable      = back_emf_en_q;
    assign absent_motor_lock_enable = abs_en_q;
    assign overspeed_lock_threshold = spd_thr_q;
    assign backemf_lock_threshold   = back_emf_thr_q;

    // codes to the decoder
    assign cfg_bus.speed_code = spd_thr_q;
    assign cfg_bus.back_emf_code  = back_emf_thr_q;

    mlfc_thr_dec u_dec (
        .cfg (cfg_bus.dec)
    );

    // decoded overspeed limit registered, one cycle behind the code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spd_pct_q <= `MLFC_RST_PCT;
        end else begin
            spd_pct_q <= cfg_bus.speed_pct;
        end
    end

    // decoded back emf limit, same lag so both limits move together
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            back_emf_pct_q <= `MLFC_RST_PCT;
        end else begin
            back_emf_pct_q <= cfg_bus.back_emf_pct;
        end
    end

    assign overspeed_limit_x10 = spd_pct_q;
    assign backemf_limit_x10   = back_emf_pct_q;

    // one pulse after any write to the setting word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_update_q <= 1'b0;
        end else begin
            cfg_update_q <= wr_fault2;
        end
    end

    assign cfg_update = cfg_update_q;

    // detector flags count only while their detector is enabled
    assign det_raw = {absent_motor_detect, backemf_lock_detect, speed_lock_detect};
    assign det_en  = {abs_en_q, back_emf_en_q, spd_en_q};
    assign det_act = det_raw & det_en;

    // edge memory, so a held flag raises one event only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            det_prev_q <= 3'h0;
        end else begin
            det_prev_q <= det_act;
        end
    end

    assign det_rise = det_act & ~det_prev_q;

    // lock fault levels for the fault handler
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_fault_q <= 3'h0;
        end else begin
            lock_fault_q <= det_act;
        end
    end

    assign lock_fault     = lock_fault_q;

    // summary registered too, so it lines up with the levels above
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            any_fault_q <= 1'b0;
        end else begin
            any_fault_q <= |det_act;
        end
    end

    assign any_lock_fault = any_fault_q;

    // event vector and write-one-to-clear
    always_comb begin
        evt_set = `MLFC_RST_EVT;
        evt_set[`MLFC_EVT_SPD]  = det_rise[0];
        evt_set[`MLFC_EVT_BACK_EMF] = det_rise[1];
        evt_set[`MLFC_EVT_ABS]  = det_rise[2];
        evt_set[`MLFC_EVT_CFG]  = wr_fault2;
    end

    assign evt_clr = wr_status ? reg_wdata[`MLFC_NUM_EVT-1:0] : `MLFC_RST_EVT;

    mlfc_sticky #(
        .N (`MLFC_NUM_EVT)
    ) u_sticky (
        .clk      (clk),
        .rst      (rst),
        .set_i    (evt_set),
        .clr_i    (evt_clr),
        .mask_i   (mask_q),
        .status_o (evt_status),
        .irq_o    (irq_raw)
    );

    assign irq = irq_raw;
endmodule // mlfc_top

/* File: verif/mlfc_top_properties.sv */
`timescale 1ns/1ps
module mlfc_top_properties #(
    parameter int ADDR_W = 8
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic              speed_lock_detect,
    input wire logic              backemf_lock_detect,
    input wire logic              absent_motor_detect,
    input wire logic              speed_lock_enable,
    input wire logic              backemf_lock_enable,
    input wire logic              absent_motor_lock_enable,
    input wire logic [2:0]        overspeed_lock_threshold,
    input wire logic [2:0]        backemf_lock_threshold,
    input wire logic [10:0]       overspeed_limit_x10,
    input wire logic [10:0]       backemf_limit_x10,
    input wire logic [2:0]        lock_fault
);
    // back emf limits per code, tenths of a percent
    localparam logic [10:0] BT [8] = '{11'h190, 11'h1c2, 11'h1f4, 11'h226, 11'h258, 11'h28a, 11'h2a3, 11'h2bc};
    logic        hit;
    logic [31:0] cfg_word;
    logic [2:0]  want;
    // write data bits tapped so the enable checks stay one signal each
    logic        reg_wdata_30;
    logic        reg_wdata_29;
    logic        reg_wdata_28;
    assign reg_wdata_30 = reg_wdata[30];
    assign reg_wdata_29 = reg_wdata[29];
    assign reg_wdata_28 = reg_wdata[28];
    // stored word as software should see it
    assign hit      = reg_addr == ADDR_W'(8'h92);
    assign cfg_word = {1'b0, speed_lock_enable, backemf_lock_enable, absent_motor_lock_enable,
                       overspeed_lock_threshold, backemf_lock_threshold, 22'h0};
    assign want     = {absent_motor_detect & absent_motor_lock_enable,
                       backemf_lock_detect & backemf_lock_enable, speed_lock_detect & speed_lock_enable};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_fault_readback: assert property (reg_rd && hit |=> reg_rdata == $past(cfg_word))
        else $error("fault setting readback wrong");
    a_reserved_reads_zero: assert property (reg_rd |=> !reg_rdata[31])
        else $error("reserved bit read as one");
    a_speed_en_write: assert property (reg_wr && hit |=> speed_lock_enable == $past(reg_wdata_30))
        else $error("speed enable not written");
    a_back_emf_en_write: assert property (reg_wr && hit |=> backemf_lock_enable == $past(reg_wdata_29))
        else $error("back emf enable not written");
    a_absent_en_write: assert property (reg_wr && hit |=> absent_motor_lock_enable == $past(reg_wdata_28))
        else $error("absent motor enable not written");
    // limits read zero while reset is released, so the first edge after it is skipped
    a_speed_limit_map: assert property (!$past(rst) |->
        overspeed_limit_x10 == 11'h514 + 11'h064 * $past(overspeed_lock_threshold))
        else $error("overspeed limit decode wrong");
    a_back_emf_limit_map: assert property (!$past(rst) |->
        backemf_limit_x10 == BT[$past(backemf_lock_threshold)])
        else $error("back emf limit decode wrong");
    a_settings_hold: assert property (!(reg_wr && hit) |=> cfg_word == $past(cfg_word))
        else $error("settings changed without a write");
    a_fault_gated: assert property (lock_fault == $past(want))
        else $error("lock fault not gated by stored enable");
endmodule // mlfc_top_properties
bind mlfc_top mlfc_top_properties #(.ADDR_W(ADDR_W)) mlfc_top_properties_i (.clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd,
    .reg_rdata, .speed_lock_detect, .backemf_lock_detect, .absent_motor_detect, .speed_lock_enable,
    .backemf_lock_enable, .absent_motor_lock_enable, .overspeed_lock_threshold, .backemf_lock_threshold,
    .overspeed_limit_x10, .backemf_limit_x10, .lock_fault);

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [31:0] w; logic [31:0] e; logic [10:0] s; logic [10:0] b;} mlfc_row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        speed_lock_detect = 1'b0;
    logic        backemf_lock_detect = 1'b0;
    logic        absent_motor_detect = 1'b0;
    logic [31:0] reg_rdata;
    logic        speed_lock_enable;
    logic        backemf_lock_enable;
    logic        absent_motor_lock_enable;
    logic [2:0]  overspeed_lock_threshold;
    logic [2:0]  backemf_lock_threshold;
    logic [10:0] overspeed_limit_x10;
    logic [10:0] backemf_limit_x10;
    logic        cfg_update;
    logic [2:0]  lock_fault;
    logic        any_lock_fault;
    logic        irq;
    logic [31:0] d;
    int          n_mismatch = 0;
    int          n_compared = 0;
    // every code of both thresholds, junk in reserved and unused bits
    mlfc_row_t rows [8] = '{
        '{32'h81ffffff, 32'h01c00000, 11'h514, 11'h2bc}, '{32'h93800001, 32'h13800000, 11'h578, 11'h2a3},
        '{32'h25400000, 32'h25400000, 11'h5dc, 11'h28a}, '{32'h47000000, 32'h47000000, 11'h640, 11'h258},
        '{32'hf8c0ffff, 32'h78c00000, 11'h6a4, 11'h226}, '{32'h0a800000, 32'h0a800000, 11'h708, 11'h1f4},
        '{32'h3c400000, 32'h3c400000, 11'h76c, 11'h1c2}, '{32'h5e000000, 32'h5e000000, 11'h7d0, 11'h190}};

    mlfc_top mlfc_top_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .speed_lock_detect,
        .backemf_lock_detect, .absent_motor_detect, .speed_lock_enable, .backemf_lock_enable,
        .absent_motor_lock_enable, .overspeed_lock_threshold, .backemf_lock_threshold, .overspeed_limit_x10,
        .backemf_limit_x10, .cfg_update, .lock_fault, .any_lock_fault, .irq);

    // 125 mhz
    always #4 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    // one-cycle write strobe, outputs sampled once that edge settled
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // read data only stands in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // cut a hang short, far beyond the roughly seventy cycles needed
    initial begin
        #100000;
        n_mismatch++;
        wrap_up;
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(8'h92, d);
        chk(d, 32'h0);
        chk(32'({overspeed_limit_x10, backemf_limit_x10}), 32'({11'h514, 11'h190}));
        for (int i = 0; i < 8; i++) begin
            wr(8'h92, rows[i].w);
            chk(32'(cfg_update), 32'h1);
            chk(32'({speed_lock_enable, backemf_lock_enable, absent_motor_lock_enable, overspeed_lock_threshold,
                backemf_lock_threshold}), 32'(rows[i].e[30:22]));
            rd(8'h92, d);
            chk(d, rows[i].e);
            chk(32'({overspeed_limit_x10, backemf_limit_x10}), 32'({rows[i].s, rows[i].b}));
        end
        // unmapped place takes nothing and reads zero
        wr(8'h55, 32'hffffffff);
        rd(8'h55, d);
        chk(d, 32'h0);
        rd(8'h92, d);
        chk(d, rows[7].e);
        // only the speed detector enabled; back emf flag must be ignored
        wr(8'h92, 32'h40000000);
        wr(8'ha0, 32'h0000000f);
        wr(8'ha1, 32'h00000001);
        @(posedge clk);
        speed_lock_detect <= 1'b1;
        backemf_lock_detect <= 1'b1;
        @(posedge clk);
        #1;
        chk(32'({lock_fault, any_lock_fault, irq}), 32'h07);
        rd(8'ha0, d);
        chk(d, 32'h1);
        wr(8'ha1, 32'h0);
        chk(32'(irq), 32'h0);
        wr(8'ha1, 32'h1);
        wr(8'ha0, 32'h1);
        chk(32'(irq), 32'h0);
        // reset in mid-run clears everything
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        #1;
        chk(32'({speed_lock_enable, lock_fault, overspeed_limit_x10}), 32'h0);
        @(posedge clk);
        rst <= 1'b0;
        rd(8'h92, d);
        chk(d, 32'h0);
        chk(32'(lock_fault), 32'h0);
        wrap_up;
    end
endmodule // testbench
